/* File: rtl/ecp_reverse_pkg.sv */
// How it works
// - Host holds the reverse acknowledge low while idle in reverse.
// - Transfer starts from idle; acknowledge is low once the last byte left.
// - Host raises acknowledge after clock low, only when it can accept.
// - After clock returns high host buffers the byte latched at acknowledge and lowers acknowledge.
// - Host stalls by holding acknowledge when full or count reached.
// - Reverse clock counts as changed only after 75 ns stable.
// - ECP mode drives push-pull; compatible mode drives open-collector.
// - Driver type changes glitch free, only while clock is high and acknowledge is low.
// - Forward: host clock low to send, high after peripheral acknowledge.
package ecp_reverse_pkg;
  localparam int unsigned CLOCK_HZ = 25000000;
  localparam int unsigned SETTLE_NS = 75;
  localparam int unsigned PERIOD_NS = 1000000000 / CLOCK_HZ;
  // Least time rounds up
  localparam int unsigned SETTLE_CYCLES =
    (SETTLE_NS + PERIOD_NS - 1) / PERIOD_NS;
  localparam int unsigned DATA_WIDTH = 8;
  localparam int unsigned BUFFER_DEPTH = 2;
  localparam logic LINE_IDLE_HIGH = 1'b1;
  localparam logic ACK_IDLE = 1'b0;

  typedef enum logic [2:0]
  {
    state_idle = 3'h0,
    state_offer = 3'h1,
    state_acked = 3'h3,
    state_fwd_strobe = 3'h2,
    state_fwd_release = 3'h6
  } state_type;
endpackage

/* File: rtl/byte_buffer.sv */
module byte_buffer
#(
  parameter int unsigned WIDTH = ecp_reverse_pkg::DATA_WIDTH,
  parameter int unsigned DEPTH = ecp_reverse_pkg::BUFFER_DEPTH
)
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [WIDTH-1:0] i_data,
  input wire logic i_valid,
  output logic o_ready,
  output logic [WIDTH-1:0] o_data,
  output logic o_valid,
  input wire logic i_ready
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("byte_buffer depth must be a power of two, at least 2");
  end

  assign o_ready = count != (AW + 1)'(DEPTH);
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_data = store[rd_ptr];

  // Storage needs no reset; valid comes from the count
  always_ff @(posedge i_clock)
  begin
    if (push)
      store[wr_ptr] <= i_data;
  end

  // Fill level after this cycle's push and pop
  always_comb
  begin
    next_count = count;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
  end

  // Pointers wrap naturally because depth is a power of two; valid is a
  // flop so the consumer sees a clean registered output
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      o_valid <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      count <= next_count;
      o_valid <= next_count != '0;
    end
  end
endmodule

/* File: rtl/ecp_reverse_handshake.sv */
module ecp_reverse_handshake
#(
  parameter int unsigned SETTLE = ecp_reverse_pkg::SETTLE_CYCLES,
  parameter int unsigned DEPTH = ecp_reverse_pkg::BUFFER_DEPTH
)
(
  input wire logic i_clock,
  input wire logic i_reset,
  // Port configuration
  input wire logic i_ecp_mode,
  input wire logic i_reverse,
  input wire logic i_count_reached,
  // Peripheral-side lines (sampled, synchronous)
  input wire logic i_periph_clk,
  input wire logic i_periph_ack,
  input wire logic [ecp_reverse_pkg::DATA_WIDTH-1:0] i_data,
  // Host acknowledge line, two signals
  output logic o_host_ack,
  output logic o_host_ack_oe,
  // Host clock line, two signals
  output logic o_host_clk,
  output logic o_host_clk_oe,
  // Forward data output
  output logic [ecp_reverse_pkg::DATA_WIDTH-1:0] o_data,
  output logic o_data_oe,
  // Forward byte source
  input wire logic [ecp_reverse_pkg::DATA_WIDTH-1:0] i_fwd_data,
  input wire logic i_fwd_valid,
  output logic o_fwd_ready,
  // Received byte sink
  output logic [ecp_reverse_pkg::DATA_WIDTH-1:0] o_rx_data,
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  output logic o_push_pull
);
  import ecp_reverse_pkg::*;

  initial
  begin
    if (SETTLE < 1 || SETTLE > 255)
      $error("settle count out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // Settle filters for the peripheral strobes

  logic [7:0] clk_count;
  logic [7:0] pack_count;
  logic clk_level;
  logic pack_level;

  // A new level is believed only after SETTLE + 1 equal samples, which
  // span SETTLE full periods and so cover the whole settle time
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      clk_level <= LINE_IDLE_HIGH;
      clk_count <= 8'h00;
    end
    else if (i_periph_clk == clk_level)
      clk_count <= 8'h00;
    else if (clk_count == 8'(SETTLE))
    begin
      clk_level <= i_periph_clk;
      clk_count <= 8'h00;
    end
    else
      clk_count <= clk_count + 8'h01;
  end

  // Same filter on the forward acknowledge
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      pack_level <= 1'b0;
      pack_count <= 8'h00;
    end
    else if (i_periph_ack == pack_level)
      pack_count <= 8'h00;
    else if (pack_count == 8'(SETTLE))
    begin
      pack_level <= i_periph_ack;
      pack_count <= 8'h00;
    end
    else
      pack_count <= pack_count + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive buffer

  logic [DATA_WIDTH-1:0] capture;
  logic capture_valid;
  logic buf_ready;

  byte_buffer
  #(
    .WIDTH(DATA_WIDTH),
    .DEPTH(DEPTH)
  )
  rx_buffer
  (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_data(capture),
    .i_valid(capture_valid),
    .o_ready(buf_ready),
    .o_data(o_rx_data),
    .o_valid(o_rx_valid),
    .i_ready(i_rx_ready)
  );

  ////////////////////////////////////////////////////////////////////////
  // Handshake state machine

  state_type state;
  logic reverse_on;
  logic can_accept;
  logic fwd_take;

  assign reverse_on = i_ecp_mode && i_reverse;
  // Acknowledge only with room left after the pending capture
  assign can_accept = buf_ready && !capture_valid && !i_count_reached;
  assign fwd_take = o_fwd_ready && i_fwd_valid;

  // Ready is a flop; once offered it is honoured, so the state machine
  // gives a forward take priority over a reverse start
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
      o_fwd_ready <= 1'b0;
    else
      o_fwd_ready <= state == state_idle && !fwd_take && i_ecp_mode &&
        !i_reverse && !pack_level;
  end

  // Capture samples the data bus, which the peripheral holds steady
  // while its clock is low; latching at acknowledge avoids the bus turn.
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      state <= state_idle;
      o_host_ack <= ACK_IDLE;
      o_host_clk <= LINE_IDLE_HIGH;
      o_data <= '0;
      capture <= '0;
      capture_valid <= 1'b0;
    end
    else
    begin
      capture_valid <= 1'b0;
      unique case (state)
        state_idle:
        begin
          o_host_ack <= ACK_IDLE;
          o_host_clk <= LINE_IDLE_HIGH;
          if (fwd_take)
          begin
            o_data <= i_fwd_data;
            state <= state_fwd_strobe;
          end
          else if (reverse_on && !clk_level)
            state <= state_offer;
        end
        state_offer:
        begin
          if (!reverse_on)
            state <= state_idle;
          else if (can_accept)
          begin
            o_host_ack <= 1'b1;
            capture <= i_data;
            state <= state_acked;
          end
          // Otherwise acknowledge stays put
        end
        state_acked:
        begin
          if (clk_level || !reverse_on)
          begin
            o_host_ack <= ACK_IDLE;
            capture_valid <= clk_level;
            state <= state_idle;
          end
        end
        state_fwd_strobe:
        begin
          o_host_clk <= 1'b0;
          if (pack_level)
            state <= state_fwd_release;
        end
        state_fwd_release:
        begin
          o_host_clk <= LINE_IDLE_HIGH;
          if (!pack_level)
            state <= state_idle;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Driver type control

  logic next_push_pull;
  assign next_push_pull = i_ecp_mode;

  // Switch driver type only while both strobes rest high or idle, so the
  // change never creates an edge; open collector releases high lines.
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
      o_push_pull <= 1'b0;
    else if (next_push_pull != o_push_pull && state == state_idle)
      o_push_pull <= next_push_pull;
  end

  // Push-pull always drives both strobes; open collector drives only a low level; data drives outside reverse
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      o_host_ack_oe <= 1'b0;
      o_host_clk_oe <= 1'b0;
      o_data_oe <= 1'b0;
    end
    else
    begin
      o_host_ack_oe <= o_push_pull || !o_host_ack;
      o_host_clk_oe <= o_push_pull || !o_host_clk;
      o_data_oe <= !i_reverse;
    end
  end
endmodule

/* File: bench/ecp_reverse_assertions.sv */
module ecp_reverse_assertions
(
  input wire logic i_clock, i_reset, i_ecp_mode, i_reverse,
  input wire logic i_count_reached, i_periph_clk, i_periph_ack,
  input wire logic o_host_ack, o_host_clk, o_host_clk_oe, o_rx_valid,
  input wire logic o_push_pull, o_host_ack_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
////////////////////
  // Ack rises only on a strobe that has settled for two samples
  a_gate_ack: assert property (!(i_ecp_mode && i_reverse) [*2]
    |-> !o_host_ack) else $error("ack out of mode");
  a_settled_low: assert property ($rose(o_host_ack) |->
    !($past(i_periph_clk, 3) || $past(i_periph_clk, 4)))
    else $error("early ack");
  a_ack_free: assert property ($rose(i_periph_clk) && o_host_ack
    |-> ##[1:4] !o_host_ack) else $error("ack stuck");
  a_stall_hold: assert property (i_count_reached && !o_host_ack
    |=> !o_host_ack) else $error("ack at count");
  a_push_byte: assert property ($fell(o_host_ack) && i_reverse
    && i_ecp_mode && $past(i_reverse) |-> ##[0:1] o_rx_valid)
    else $error("byte lost");
  a_oc_release: assert property ((!o_push_pull && o_host_clk) [*2]
    |-> !o_host_clk_oe) else $error("drives high");
  a_oc_ack_free: assert property ((!o_push_pull && o_host_ack) [*2]
    |-> !o_host_ack_oe) else $error("ack drives high");
  a_pp_drive: assert property (o_push_pull [*2]
    |-> o_host_ack_oe && o_host_clk_oe) else $error("push-pull idle");
  a_clean_swap: assert property ($changed(o_push_pull) |->
    $stable(o_host_clk) && $stable(o_host_ack)) else $error("glitch");
  a_fwd_rise: assert property ($rose(o_host_clk) |->
    $past(i_periph_ack, 2)) else $error("early strobe");
  c_rev: cover property ($fell(o_host_ack));
  c_fwd: cover property ($rose(o_host_clk));
  c_swap: cover property ($changed(o_push_pull));
endmodule
bind ecp_reverse_handshake ecp_reverse_assertions chk (.*);

/* File: bench/ecp_periph_model.sv */
module ecp_periph_model
(
  input wire logic i_clock, i_host_ack, i_host_clk,
  output logic o_periph_clk = 1'h1,
  output logic o_periph_ack = 1'h0,
  output logic [ecp_reverse_pkg::DATA_WIDTH-1:0] o_data = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;
////////////////////
  // Data inverted once taken, so a stale byte never looks fresh
  task automatic send(input logic [7:0] v);
    @(posedge i_clock);
    o_data <= v;
    repeat ($urandom_range(4, 1)) @(posedge i_clock);
    o_periph_clk <= 1'h0;
    do @(posedge i_clock); while (i_host_ack !== 1'h1);
    o_periph_clk <= 1'h1;
    do @(posedge i_clock); while (i_host_ack !== 1'h0);
    o_data <= ~v;
  endtask
  // Dip shorter than the settle time
  task automatic glitch();
    @(posedge i_clock);
    o_periph_clk <= 1'h0;
    @(posedge i_clock);
    o_periph_clk <= 1'h1;
  endtask
  // Forward acknowledge follows the host strobe
  always @(posedge i_clock)
    o_periph_ack <= (i_host_clk === 1'h0);
endmodule

/* File: bench/tb_ecp_reverse_handshake.sv */
module tb_ecp_reverse_handshake;
  timeunit 1ns;
  timeprecision 1ns;
  import ecp_reverse_pkg::*;
  logic i_clock = 1'h0, i_reset = 1'h1, i_ecp_mode = 1'h1, hold = 1'h0;
  logic i_reverse = 1'h1, i_count_reached = 1'h0, i_fwd_valid = 1'h0;
  logic i_rx_ready = 1'h0, i_periph_clk, i_periph_ack, o_host_ack;
  logic o_host_ack_oe, o_host_clk, o_host_clk_oe, o_data_oe, o_fwd_ready;
  logic o_rx_valid, o_push_pull;
  logic [DATA_WIDTH-1:0] i_data, o_data, o_rx_data, b, i_fwd_data = 8'h00;
  logic [DATA_WIDTH-1:0] q[$];
  int error_cnt = 0, checks_done = 0, cyc = 0;
  ecp_reverse_handshake uut (.*);
  ecp_periph_model per (.i_clock, .i_host_ack(o_host_ack),
    .i_host_clk(o_host_clk), .o_periph_clk(i_periph_clk),
    .o_periph_ack(i_periph_ack), .o_data(i_data));
////////////////////
  task automatic check(input logic [8:0] seen, input logic [8:0] want);
    checks_done++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("wrong value at %0t: %h expected %h", $time, seen, want);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic drain();
    for (int k = 0; k < 80 && q.size() > 0; k++)
      @(posedge i_clock);
    check(9'(q.size()), 9'h000);
    wait fork;
  endtask
  // Offer a byte while the handshake is barred, then lift the bar
  task automatic stalled(input logic [7:0] v);
    q.push_back(v);
    fork
      per.send(v);
    join_none
    repeat (30) @(posedge i_clock);
    check(o_host_ack, 9'h000);
    {hold, i_count_reached, i_reverse} <= 3'h1;
    drain();
  endtask
  // Hang guard well above the several hundred cycles needed
  always #20 i_clock = ~i_clock;
  always @(posedge i_clock)
  begin
    if (++cyc == 20000)
      begin
      error_cnt++;
      end_sim();
    end
    if (o_rx_valid === 1'h1 && i_rx_ready === 1'h1)
      check(o_rx_data, q.pop_front());
    i_rx_ready <= !hold && ($urandom_range(3) != 0);
  end
  initial
  begin
    void'($urandom(36560));
    repeat (2) @(posedge i_clock);
    i_reset <= 1'h0;
    check({o_host_ack, o_host_clk}, 9'h001);
    repeat (20)
    begin
      b = 8'($urandom);
      q.push_back(b);
      per.send(b);
    end
    drain();
    check(o_push_pull, 9'h001);
    $display("reverse done");
    // Full buffer, terminal count, wrong direction, short dip
    hold <= 1'h1;
    q = '{8'h00, 8'hFF};
    per.send(8'h00);
    per.send(8'hFF);
    stalled(8'hA5);
    i_count_reached <= 1'h1;
    stalled(8'h5A);
    i_reverse <= 1'h0;
    stalled(8'hC3);
    per.glitch();
    repeat (10) @(posedge i_clock);
    check(o_host_ack, 9'h000);
    $display("stalls done");
    i_reverse <= 1'h0;
    b = 8'($urandom);
    i_fwd_data <= b;
    i_fwd_valid <= 1'h1;
    do @(posedge i_clock); while (o_fwd_ready !== 1'h1);
    i_fwd_valid <= 1'h0;
    do @(posedge i_clock); while (o_host_clk !== 1'h0);
    check({o_data_oe, o_data}, {1'h1, b});
    i_ecp_mode <= 1'h0;
    repeat (12) @(posedge i_clock);
    check(o_push_pull, 9'h000);
    $display("forward done");
    end_sim();
  end
endmodule
